// File: dmccfg_regs.sv
// dram controller configuration bank with axi4-lite slave and consumers
// Function
// - build info bit 28 shows whether error correction is present
// - build info bits 25:24 show controller burst length in phy beats
// - build info bits 18:16 show request queue depth in bursts
// - build info bits 13:12 show rank selects per interface
// - build info bits 9:8 show effective phy interface width
// - command register write only, any state, low three bits issue command
// - all pending configuration registers readable and writable in any state
// - bank hash enable makes system decode hash the bank bits
// - stripe field picks slice of low 14 bits for two page bits
// - two-bit pattern picks order of rank, bank, row, column extraction
// - sixteen-bit mask clears system address bits 43 to 28
// - three-bit field selects address translation mode
// - auto self-refresh after idle for programmed refresh intervals, 1 to 15
// - auto power-down places memory in power-down when idle
// - clock stop halts memory clock in self-refresh, reset, max power-down
// - turnaround counts in prescaler periods chosen by two-bit field
// - high-high and high classes wait their own limit between turnarounds
// - medium and low classes wait their own limit between turnarounds
module dmccfg_regs #(
    parameter logic       ECC_PRESENT = 1'b1,
    parameter logic [1:0] BURST_CFG   = 2'h1,
    parameter logic [2:0] QDEPTH_CFG  = 3'h3,
    parameter logic [1:0] RANKSEL_CFG = 2'h1,
    parameter logic [1:0] PHYW_CFG    = 2'h2,
    parameter int         IDLE_W      = 4
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rstn,
    // axi4-lite write address and data
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [11:0]        awaddr,
    input  wire logic               wvalid,
    output logic                    wready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    // axi4-lite write response
    output logic                    bvalid,
    input  wire logic               bready,
    output logic [1:0]              bresp,
    // axi4-lite read
    input  wire logic               arvalid,
    output logic                    arready,
    input  wire logic [11:0]        araddr,
    output logic                    rvalid,
    input  wire logic               rready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    // state command toward the state machine
    output logic                    cmdValid,
    output logic [2:0]              cmdCode,
    // system address decode
    input  wire logic [43:0]        sysAddr,
    output logic [43:0]             maskedAddr,
    output logic [1:0]              pageLowBits,
    output logic                    bankHashOn,
    output logic [1:0]              decodePattern,
    output logic [2:0]              mapMode,
    // low power control
    input  wire logic               memIdle,
    input  wire logic               refreshTick,
    input  wire logic               memInReset,
    input  wire logic               maxPowerDown,
    output dmccfg_pkg::dmccfg_lp_t  lowPower,
    // turnaround arbitration
    input  wire dmccfg_pkg::dmccfg_qos_t qosPresent,
    input  wire logic               turnDone,
    output logic                    turnAllowed
);
    // idle counter must be able to reach the widest 4-bit period
    if (IDLE_W < 4) begin : g_idle_w_check
        $error("IDLE_W must hold the 4-bit period");
    end

    logic [31:0] geo_q, dec_q, map_q, pwr_q, ta_q;
    logic [11:0] awAddr_q;
    logic        awHave_q, wHave_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic [IDLE_W-1:0] idleCnt_q;
    logic        doWrite;
    logic [31:0] buildInfo;

    // merge byte lanes, keep only implemented bits
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb,
                                          input logic [31:0] msk);
        logic [31:0] lane;
        lane  = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = ((old & ~lane) | (nw & lane)) & msk;
    endfunction : merge

    // build info is constant wiring from parameters
    always_comb begin
        buildInfo = 32'h0000_0000;
        buildInfo[dmccfg_pkg::BI_ECC] = ECC_PRESENT;
        buildInfo[dmccfg_pkg::BI_BURST +: 2] = BURST_CFG;
        buildInfo[dmccfg_pkg::BI_QDEPTH +: 3] = QDEPTH_CFG;
        buildInfo[dmccfg_pkg::BI_RANKSEL +: 2] = RANKSEL_CFG;
        buildInfo[dmccfg_pkg::BI_PHYW +: 2] = PHYW_CFG;
    end

    // address and data captured independently, either order
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            awHave_q <= 1'b0;
            awAddr_q <= 12'h000;
        end else if (doWrite) begin
            awHave_q <= 1'b0;
        end else if (awvalid && awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= awaddr;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wHave_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else if (doWrite) begin
            wHave_q <= 1'b0;
        end else if (wvalid && wready) begin
            wHave_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end
    end

    // ready levels from flops; each drops when its item is taken
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            awready <= awready ? !awvalid
                : !awHave_q && (!bvalid || bready);
            wready  <= wready ? !wvalid
                : !wHave_q && (!bvalid || bready);
        end
    end

    assign doWrite = awHave_q && wHave_q && !bvalid;

    // write response; unmapped or read-only target gets slverr
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp  <= dmccfg_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            case (awAddr_q)
                dmccfg_pkg::OFF_STATE_CMD,
                dmccfg_pkg::OFF_GEOMETRY,
                dmccfg_pkg::OFF_DECODE,
                dmccfg_pkg::OFF_SYSMAP,
                dmccfg_pkg::OFF_POWER,
                dmccfg_pkg::OFF_TURNAROUND: bresp <= dmccfg_pkg::RESP_OKAY;
                default: bresp <= dmccfg_pkg::RESP_SLVERR;
            endcase
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // pending registers, writable in any state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            geo_q <= dmccfg_pkg::RST_GEOMETRY;
            dec_q <= dmccfg_pkg::RST_DECODE;
            map_q <= dmccfg_pkg::RST_SYSMAP;
            pwr_q <= dmccfg_pkg::RST_POWER;
            ta_q  <= dmccfg_pkg::RST_TURNAROUND;
        end else if (doWrite) begin
            case (awAddr_q)
                dmccfg_pkg::OFF_GEOMETRY: geo_q <= merge(geo_q, wData_q,
                    wStrb_q, dmccfg_pkg::MSK_GEOMETRY);
                dmccfg_pkg::OFF_DECODE: dec_q <= merge(dec_q, wData_q,
                    wStrb_q, dmccfg_pkg::MSK_DECODE);
                dmccfg_pkg::OFF_SYSMAP: map_q <= merge(map_q, wData_q,
                    wStrb_q, dmccfg_pkg::MSK_SYSMAP);
                dmccfg_pkg::OFF_POWER: pwr_q <= merge(pwr_q, wData_q,
                    wStrb_q, dmccfg_pkg::MSK_POWER);
                dmccfg_pkg::OFF_TURNAROUND: ta_q <= merge(ta_q, wData_q,
                    wStrb_q, dmccfg_pkg::MSK_TURNAROUND);
                default: ;
            endcase
        end
    end

    // command strobe: one cycle, needs byte lane 0
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmdValid <= 1'b0;
            cmdCode  <= 3'h0;
        end else begin
            cmdValid <= doWrite && wStrb_q[0]
                && awAddr_q == dmccfg_pkg::OFF_STATE_CMD;
            if (doWrite && wStrb_q[0]
                && awAddr_q == dmccfg_pkg::OFF_STATE_CMD)
                cmdCode <= wData_q[2:0];
        end
    end

    // read channel; command register is not readable
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rvalid  <= 1'b0;
            arready <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= dmccfg_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid  <= 1'b1;
            arready <= 1'b0; // one read in flight at a time
            rresp   <= dmccfg_pkg::RESP_OKAY;
            case (araddr)
                dmccfg_pkg::OFF_BUILD_INFO: rdata <= buildInfo;
                dmccfg_pkg::OFF_GEOMETRY:   rdata <= geo_q;
                dmccfg_pkg::OFF_DECODE:     rdata <= dec_q;
                dmccfg_pkg::OFF_SYSMAP:     rdata <= map_q;
                dmccfg_pkg::OFF_POWER:      rdata <= pwr_q;
                dmccfg_pkg::OFF_TURNAROUND: rdata <= ta_q;
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= dmccfg_pkg::RESP_SLVERR;
                end
            endcase
        end else if (!rvalid || rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // address decode outputs, registered
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            maskedAddr    <= 44'h000_0000_0000;
            pageLowBits   <= 2'h0;
            bankHashOn    <= 1'b0;
            decodePattern <= 2'h0;
            mapMode       <= 3'h0;
        end else begin
            maskedAddr <= sysAddr & ~{map_q[dmccfg_pkg::MAP_MASK +: 16],
                28'h000_0000};
            // stripe 0 keeps page bits at the natural column position
            pageLowBits <= 2'(sysAddr[dmccfg_pkg::STRIPE_SPAN-1:0]
                >> (4'd6 + 4'(dec_q[dmccfg_pkg::DEC_STRIPE +: 3])));
            bankHashOn    <= geo_q[dmccfg_pkg::GEO_HASH];
            decodePattern <= dec_q[1:0];
            mapMode       <= map_q[2:0];
        end
    end

    // idle refresh intervals since last activity
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            idleCnt_q <= '0;
        else if (!memIdle)
            idleCnt_q <= '0;
        else if (refreshTick && idleCnt_q != {IDLE_W{1'b1}})
            idleCnt_q <= idleCnt_q + 1'b1;
    end

    // low power decisions; period 0 is treated as 1
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lowPower <= '0;
        end else begin
            lowPower.selfRefresh <= pwr_q[dmccfg_pkg::PWR_ASR] && memIdle
                && idleCnt_q >= IDLE_W'(pwr_q[dmccfg_pkg::PWR_PERIOD +: 4])
                && idleCnt_q != '0;
            lowPower.powerDown <= pwr_q[dmccfg_pkg::PWR_APD]
                && memIdle;
            lowPower.clockStop <= pwr_q[dmccfg_pkg::PWR_CKSTOP]
                && (lowPower.selfRefresh || memInReset
                    || maxPowerDown);
        end
    end

    // turnaround spacing lives in its own timer
    dmccfg_turn_timer #(
        .PRE_W(2)
    ) u_turn (
        .mclk       (mclk),
        .rstn       (rstn),
        .preSel     (ta_q[dmccfg_pkg::TA_PRE +: 2]),
        .limitHh    (ta_q[dmccfg_pkg::TA_HH +: 4]),
        .limitH     (ta_q[dmccfg_pkg::TA_H +: 4]),
        .limitM     (ta_q[dmccfg_pkg::TA_M +: 4]),
        .limitL     (ta_q[dmccfg_pkg::TA_L +: 4]),
        .qosPresent (qosPresent),
        .turnDone   (turnDone),
        .turnAllowed(turnAllowed)
    );

    chk_cmd_pulse : assert property (
        @(posedge mclk) disable iff (!rstn)
        cmdValid |=> !cmdValid)
        else $error("command strobe longer than one cycle");

    chk_build_read : assert property (
        @(posedge mclk) disable iff (!rstn)
        arvalid && arready && araddr == dmccfg_pkg::OFF_BUILD_INFO
        |=> rdata[dmccfg_pkg::BI_ECC] == ECC_PRESENT
            && rdata[dmccfg_pkg::BI_BURST +: 2] == BURST_CFG)
        else $error("build info read wrong");

    chk_cmd_noread : assert property (
        @(posedge mclk) disable iff (!rstn)
        arvalid && arready && araddr == dmccfg_pkg::OFF_STATE_CMD
        |=> rdata == 32'h0000_0000)
        else $error("command register returned data");

    chk_reserved_zero : assert property (
        @(posedge mclk) disable iff (!rstn)
        (ta_q & ~dmccfg_pkg::MSK_TURNAROUND) == 32'h0000_0000
        && (geo_q & ~dmccfg_pkg::MSK_GEOMETRY) == 32'h0000_0000)
        else $error("reserved bits set");

    chk_mask_apply : assert property (
        @(posedge mclk) disable iff (!rstn)
        map_q[31:16] == 16'hFFFF && $stable(map_q) |=>
        maskedAddr[43:28] == 16'h0000)
        else $error("address mask not applied");

    chk_pd_idle : assert property (
        @(posedge mclk) disable iff (!rstn)
        !memIdle |=> !lowPower.powerDown && !lowPower.selfRefresh)
        else $error("low power entered while busy");

    chk_clk_stop : assert property (
        @(posedge mclk) disable iff (!rstn)
        lowPower.clockStop |-> $past(pwr_q[dmccfg_pkg::PWR_CKSTOP]))
        else $error("clock stopped while disabled");

    chk_write_lands : assert property (
        @(posedge mclk) disable iff (!rstn)
        doWrite && awAddr_q == dmccfg_pkg::OFF_POWER && wStrb_q == 4'hF
        |=> pwr_q == ($past(wData_q) & dmccfg_pkg::MSK_POWER))
        else $error("power register write lost");

endmodule : dmccfg_regs

// File: dmccfg_pkg.sv
// package: register map, field layout and carriers of the dram config bank
package dmccfg_pkg;

    // register byte offsets
    localparam logic [11:0] OFF_BUILD_INFO  = 12'h004;
    localparam logic [11:0] OFF_STATE_CMD   = 12'h008;
    localparam logic [11:0] OFF_GEOMETRY    = 12'h010;
    localparam logic [11:0] OFF_DECODE      = 12'h014;
    localparam logic [11:0] OFF_SYSMAP      = 12'h01C;
    localparam logic [11:0] OFF_POWER       = 12'h020;
    localparam logic [11:0] OFF_TURNAROUND  = 12'h028;

    // reset values
    localparam logic [31:0] RST_GEOMETRY    = 32'h0003_0202;
    localparam logic [31:0] RST_DECODE      = 32'h0000_0000;
    localparam logic [31:0] RST_SYSMAP      = 32'h0000_0000;
    localparam logic [31:0] RST_POWER       = 32'h0000_0020;
    localparam logic [31:0] RST_TURNAROUND  = 32'h0F0F_0F0F;

    // writable bit masks; everything else reads zero
    localparam logic [31:0] MSK_GEOMETRY    = 32'h1307_0707;
    localparam logic [31:0] MSK_DECODE      = 32'h0000_0073;
    localparam logic [31:0] MSK_SYSMAP      = 32'hFFFF_0007;
    localparam logic [31:0] MSK_POWER       = 32'h0000_00FE;
    localparam logic [31:0] MSK_TURNAROUND  = 32'hCF0F_0F0F;

    // build info field positions
    localparam int BI_ECC     = 28;
    localparam int BI_BURST   = 24;
    localparam int BI_QDEPTH  = 16;
    localparam int BI_RANKSEL = 12;
    localparam int BI_PHYW    = 8;

    // field positions used by the block's own logic
    localparam int GEO_HASH   = 28;
    localparam int DEC_STRIPE = 4;
    localparam int MAP_MASK   = 16;
    localparam int PWR_PERIOD = 4;
    localparam int PWR_ASR    = 3;
    localparam int PWR_APD    = 2;
    localparam int PWR_CKSTOP = 1;
    localparam int TA_PRE     = 30;
    localparam int TA_HH      = 24;
    localparam int TA_H       = 16;
    localparam int TA_M       = 8;
    localparam int TA_L       = 0;

    // system address layout
    localparam int SYS_AW      = 44;
    localparam int MASK_LSB    = 28;
    localparam int STRIPE_SPAN = 14;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // qos class presence
    typedef struct packed {
        logic hiHi;
        logic hi;
        logic med;
        logic low;
    } dmccfg_qos_t;

    // low power decisions toward the dram
    typedef struct packed {
        logic selfRefresh;
        logic powerDown;
        logic clockStop;
    } dmccfg_lp_t;

endpackage : dmccfg_pkg

// File: dmccfg_turn_timer.sv
// turnaround spacing timer: prescaler plus per-class wait counter
module dmccfg_turn_timer #(
    parameter int PRE_W = 2
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rstn,
    // configuration
    input  wire logic [PRE_W-1:0]   preSel,
    input  wire logic [3:0]         limitHh,
    input  wire logic [3:0]         limitH,
    input  wire logic [3:0]         limitM,
    input  wire logic [3:0]         limitL,
    // arbiter side
    input  wire dmccfg_pkg::dmccfg_qos_t qosPresent,
    input  wire logic               turnDone,
    output logic                    turnAllowed
);
    logic [7:0] preCnt_q;
    logic [3:0] waitCnt_q;
    logic [3:0] limit;
    logic       preTick;

    // an 8-bit prescaler serves at most a 2-bit select
    if (PRE_W < 1 || PRE_W > 2) begin : g_pre_w_check
        $error("PRE_W must be 1 or 2");
    end

    // prescaler period is 2^(2*sel) cycles: 1, 4, 16 or 64
    function automatic logic [7:0] preLast(input logic [PRE_W-1:0] sel);
        preLast = 8'((16'h0001 << (2 * sel)) - 16'h0001);
    endfunction : preLast

    // highest class present picks the limit
    always_comb begin
        if (qosPresent.hiHi)
            limit = limitHh;
        else if (qosPresent.hi)
            limit = limitH;
        else if (qosPresent.med)
            limit = limitM;
        else
            limit = limitL;
    end

    assign preTick = (preCnt_q >= preLast(preSel));

    // prescaler counts cycles into periods
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            preCnt_q <= 8'h00;
        else if (preTick || turnDone)
            preCnt_q <= 8'h00;
        else
            preCnt_q <= preCnt_q + 8'h01;
    end

    // periods since last turnaround, saturating at 15
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            waitCnt_q <= 4'h0;
        else if (turnDone)
            waitCnt_q <= 4'h0;
        else if (preTick && waitCnt_q != 4'hF)
            waitCnt_q <= waitCnt_q + 4'h1;
    end

    // registered so the top output stays flop-driven
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            turnAllowed <= 1'b0;
        else
            turnAllowed <= !turnDone && (waitCnt_q >= limit);
    end

    chk_wait_counts : assert property (
        @(posedge mclk) disable iff (!rstn)
        turnDone |=> waitCnt_q == 4'h0)
        else $error("wait count not cleared after turnaround");

endmodule : dmccfg_turn_timer

// File: dmccfg_regs_tb.sv
// self-checking testbench for the dram configuration register bank
`define CHK(n, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
end

module dmccfg_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // stimulus side
    logic                    mclk, rstn, awvalid, wvalid, bready;
    logic                    arvalid, rready, turnDone;
    logic                    memIdle, refreshTick, memInReset, maxPowerDown;
    logic [11:0]             awaddr, araddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic [43:0]             sysAddr;
    dmccfg_pkg::dmccfg_qos_t qosPresent;
    // design outputs
    logic                    awready, wready, bvalid, arready, rvalid;
    logic                    cmdValid, bankHashOn, turnAllowed;
    logic [1:0]              bresp, rresp, pageLowBits, decodePattern;
    logic [31:0]             rdata, rd;
    logic [2:0]              cmdCode, mapMode;
    logic [43:0]             maskedAddr;
    logic [1:0]              rsp;
    dmccfg_pkg::dmccfg_lp_t  lowPower;
    int                      err_count, compares, pulses, lim;

    // pending registers: offset, reset value, writable bits
    localparam logic [11:0] OF [5] = '{12'h010, 12'h014, 12'h01C,
                                       12'h020, 12'h028};
    localparam logic [31:0] RV [5] = '{32'h0003_0202, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0020, 32'h0F0F_0F0F};
    localparam logic [31:0] MK [5] = '{32'h1307_0707, 32'h0000_0073,
        32'hFFFF_0007, 32'h0000_00FE, 32'hCF0F_0F0F};
    // build info from the chosen build parameters, reserved bits zero
    localparam logic [31:0] BI = {3'h0, 1'b1, 2'h0, 2'h1, 5'h00, 3'h3,
                                  2'h0, 2'h1, 2'h0, 2'h2, 8'h00};

    dmccfg_regs dut (.mclk, .rstn, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .cmdValid,
        .cmdCode, .sysAddr, .maskedAddr, .pageLowBits, .bankHashOn,
        .decodePattern, .mapMode, .memIdle, .refreshTick, .memInReset,
        .maxPowerDown, .lowPower, .qosPresent, .turnDone, .turnAllowed);

    // 40 mhz clock
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end

    // command pulses counted on every edge, since each lasts one cycle
    always @(posedge mclk) begin
        if (cmdValid === 1'b1) pulses++;
    end

    // axi4-lite write; address and data offered together
    task automatic axw(input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        logic ad;
        logic wd;
        @(posedge mclk);
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd)) begin
            @(posedge mclk);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 0;
            end
        end
        do @(posedge mclk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 0;
    endtask : axw

    // axi4-lite read
    task automatic axr(input logic [11:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 0;
    endtask : axr

    // one-cycle pulse on a strobe input
    task automatic pulse(input int which);
        @(posedge mclk);
        if (which == 0) refreshTick <= 1;
        else turnDone <= 1;
        @(posedge mclk);
        refreshTick <= 0;
        turnDone <= 0;
    endtask : pulse

    task automatic tally_and_finish;
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #500us;
        err_count++;
        tally_and_finish();
    end

    initial begin
        rstn = 0;
        {awvalid, wvalid, bready, arvalid, rready, turnDone} = '0;
        {memIdle, refreshTick, memInReset, maxPowerDown} = '0;
        {awaddr, araddr, wdata, wstrb, sysAddr, qosPresent} = '0;
        repeat (3) @(posedge mclk);
        rstn <= 1;
        // reset values, all-ones, byte lane and clear on each register
        for (int i = 0; i < 5; i++) begin
            axr(OF[i]);
            `CHK("reset value", RV[i], rd)
            axw(OF[i], 32'hFFFF_FFFF, 4'hF);
            `CHK("write resp", dmccfg_pkg::RESP_OKAY, rsp)
            axr(OF[i]);
            `CHK("ones readback", MK[i], rd)
            axw(OF[i], 32'h0000_0000, 4'h1);
            axr(OF[i]);
            `CHK("lane readback", MK[i] & 32'hFFFF_FF00, rd)
            axw(OF[i], 32'h0000_0000, 4'hF);
        end
        // build info is read only; command register and holes refuse
        axw(12'h004, 32'hFFFF_FFFF, 4'hF);
        `CHK("ro write resp", dmccfg_pkg::RESP_SLVERR, rsp)
        axr(12'h004);
        `CHK("build info", BI, rd)
        axr(12'h008);
        `CHK("cmd read data", 32'h0000_0000, rd)
        `CHK("cmd read resp", dmccfg_pkg::RESP_SLVERR, rsp)
        axr(12'h0FC);
        `CHK("hole read resp", dmccfg_pkg::RESP_SLVERR, rsp)
        // every command code, reserved bits set, one pulse each
        for (int c = 0; c < 8; c++) begin
            lim = pulses;
            axw(12'h008, 32'hFFFF_FFF8 | c, 4'hF);
            repeat (2) @(posedge mclk);
            `CHK("cmd pulses", lim + 1, pulses)
            `CHK("cmd code", 3'(c), cmdCode)
        end
        lim = pulses;
        axw(12'h008, 32'h0000_0005, 4'h0);
        repeat (2) @(posedge mclk);
        `CHK("masked cmd", lim, pulses)
        // address decode controls; geometry as software sets it
        axw(12'h010, 32'h1003_0202, 4'hF);
        axr(12'h010);
        `CHK("geometry", 32'h1003_0202, rd)
        axw(12'h01C, 32'hA5A5_0005, 4'hF);
        sysAddr <= 44'hFFF_FFFF_ED6B;
        repeat (3) @(posedge mclk);
        `CHK("bank hash", 1'b1, bankHashOn)
        `CHK("masked addr", 44'h5A5_AFFF_ED6B, maskedAddr)
        `CHK("map mode", 3'h5, mapMode)
        for (int f = 0; f < 8; f++) begin
            axw(12'h014, (f << 4) | (f & 3), 4'hF);
            repeat (3) @(posedge mclk);
            `CHK("page bits", 2'(14'h2D6B >> (6 + f)), pageLowBits)
            `CHK("pattern", 2'(f), decodePattern)
        end
        // power-down on idle, then self-refresh after two intervals
        axw(12'h020, 32'h0000_0024, 4'hF);
        memIdle <= 1;
        repeat (3) @(posedge mclk);
        `CHK("power down", 1'b1, lowPower.powerDown)
        memIdle <= 0;
        axw(12'h020, 32'h0000_002A, 4'hF);
        memIdle <= 1;
        pulse(0);
        repeat (3) @(posedge mclk);
        `CHK("early sref", 1'b0, lowPower.selfRefresh)
        pulse(0);
        repeat (3) @(posedge mclk);
        `CHK("self refresh", 1'b1, lowPower.selfRefresh)
        `CHK("clock stop sr", 1'b1, lowPower.clockStop)
        memIdle <= 0;
        memInReset <= 1;
        repeat (3) @(posedge mclk);
        `CHK("clock stop rst", 1'b1, lowPower.clockStop)
        memInReset <= 0;
        repeat (3) @(posedge mclk);
        `CHK("clock runs", 1'b0, lowPower.clockStop)
        // turnaround spacing per class, then a longer prescaler
        axw(12'h028, 32'h0204_0608, 4'hF);
        for (int k = 0; k < 4; k++) begin
            qosPresent <= 4'b1000 >> k;
            lim = 2 + 2 * k;
            pulse(1);
            @(posedge mclk);
            `CHK("turn held", 1'b0, turnAllowed)
            // the limit'th period ends one edge before the level rises
            repeat (lim) @(posedge mclk);
            `CHK("turn wait", 1'b0, turnAllowed)
            @(posedge mclk);
            `CHK("turn free", 1'b1, turnAllowed)
        end
        axw(12'h028, 32'h4000_0002, 4'hF);
        pulse(1);
        // two periods of four cycles, then one edge for the flop
        repeat (9) @(posedge mclk);
        `CHK("prescaled held", 1'b0, turnAllowed)
        @(posedge mclk);
        `CHK("prescaled free", 1'b1, turnAllowed)
        tally_and_finish();
    end
endmodule : dmccfg_regs_tb
